// file: dcip_ctrl.sv
// control-input front end: command capture, clock gate, power states, termination
// assumes ref_clk is the true timing clock; the controller drives all inputs
`timescale 1ns/100ps
`include "dcip_defines.svh"
module dcip_ctrl (
  input  wire logic                   ref_clk,              // timing clock
  input  wire logic                   resetn,               // async reset
  input  wire logic                   clock_gate,           // clock-gate input
  input  wire logic                   chip_select_n,        // chip select, low active
  input  wire logic                   row_strobe_n,         // row strobe
  input  wire logic                   col_strobe_n,         // column strobe
  input  wire logic                   write_enable_n,       // write enable
  input  wire logic [2:0]             bank_addr,            // bank address
  input  wire logic [12:0]            addr,                 // address
  input  wire logic                   termination_control,  // termination request
  input  wire logic                   ext_term_disable,     // setting-reg-one disables termination
  input  wire logic                   any_row_open,         // some bank has an open row
  input  wire logic [`DCIP_DQ_W-1:0]  rd_rise,              // read item, high phase
  input  wire logic [`DCIP_DQ_W-1:0]  rd_fall,              // read item, low phase
  output logic      [3:0]             cmd_code,             // decoded command
  output logic                        cmd_valid,            // command accepted pulse
  output logic      [2:0]             cmd_bank,             // captured bank
  output logic      [12:0]            cmd_addr,             // captured address
  output logic      [3:0]             power_state,          // one-hot power state
  output logic                        int_clk_en,           // internal clocks running
  output logic                        in_buf_en,            // command/data input buffers on
  output logic                        clk_buf_en,           // timing clock receivers on
  output logic                        out_drv_en,           // output drivers on
  output logic      [`DCIP_TERM_W-1:0] term_en,             // per-line termination
  output logic      [`DCIP_DQ_W-1:0]  dq_out                // double-rate read data
);
  dcip_pkg::dcip_state_t st_q;
  dcip_pkg::dcip_state_t st_d;
  logic [3:0]  cmd_q;
  logic [3:0]  cmd_d;
  logic        vld_q;
  logic        vld_d;
  logic [2:0]  bank_q;
  logic [2:0]  bank_d;
  logic [12:0] addr_q;
  logic [12:0] addr_d;
  logic        term_q;
  logic        term_d;
  logic [3:0]  raw_cmd;
  logic        sref_wake;

  // chip select forms the top bit of the command code
  function automatic logic [3:0] pack_cmd(input logic cs, input logic r,
                                          input logic c, input logic w);
    pack_cmd = {cs, r, c, w};
  endfunction

  assign raw_cmd = pack_cmd(chip_select_n, row_strobe_n, col_strobe_n, write_enable_n);

  always_comb
  begin
    st_d   = st_q;
    cmd_d  = `DCIP_CMD_NOP;
    vld_d  = 1'b0;
    bank_d = bank_q;
    addr_d = addr_q;
    term_d = term_q;
    unique case (st_q)
      dcip_pkg::DCIP_ST_ACTIVE:
      begin
        if (!clock_gate)
        begin
          // refresh issued with gate low means self refresh entry
          if (!any_row_open && !chip_select_n && raw_cmd == `DCIP_CMD_REF)
            st_d = dcip_pkg::DCIP_ST_SREF;
          else if (any_row_open)
            st_d = dcip_pkg::DCIP_ST_APD;
          else
            st_d = dcip_pkg::DCIP_ST_PPD;
        end
        else if (!raw_cmd[`DCIP_CMD_CS_BIT])
        begin
          cmd_d  = raw_cmd;
          vld_d  = 1'b1;
          bank_d = bank_addr;
          addr_d = addr;
        end
        term_d = termination_control & ~ext_term_disable;
      end
      dcip_pkg::DCIP_ST_PPD, dcip_pkg::DCIP_ST_APD:
      begin
        if (clock_gate)
          st_d = dcip_pkg::DCIP_ST_ACTIVE;
        term_d = termination_control & ~ext_term_disable;
      end
      dcip_pkg::DCIP_ST_SREF:
      begin
        term_d = 1'b0;
        if (clock_gate)
          st_d = dcip_pkg::DCIP_ST_ACTIVE;
      end
    endcase
  end

  // combinational wake on gate high turns on clocks and clock receivers in self refresh without any clock edge
  assign sref_wake = (st_q == dcip_pkg::DCIP_ST_SREF) & clock_gate;

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_q   <= dcip_pkg::DCIP_ST_ACTIVE;
      cmd_q  <= `DCIP_CMD_NOP;
      vld_q  <= 1'b0;
      bank_q <= '0;
      addr_q <= '0;
      term_q <= 1'b0;
    end
    else
    begin
      st_q   <= st_d;
      cmd_q  <= cmd_d;
      vld_q  <= vld_d;
      bank_q <= bank_d;
      addr_q <= addr_d;
      term_q <= term_d;
    end
  end

  assign cmd_code    = cmd_q;
  assign cmd_valid   = vld_q;
  assign cmd_bank    = bank_q;
  assign cmd_addr    = addr_q;
  assign power_state = st_q;
  // gate state combined with async wake so clocks restart while clock is stopped
  assign int_clk_en  = (st_q == dcip_pkg::DCIP_ST_ACTIVE) | sref_wake;
  assign out_drv_en  = (st_q == dcip_pkg::DCIP_ST_ACTIVE);
  assign in_buf_en   = (st_q == dcip_pkg::DCIP_ST_ACTIVE);
  assign clk_buf_en  = (st_q != dcip_pkg::DCIP_ST_SREF) | sref_wake;
  // all 16 data lines, both strobe pairs, both masks share one enable
  assign term_en     = term_q ? `DCIP_TERM_ALL : `DCIP_TERM_NONE;

  dcip_ddr_out u_ddr_out (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .enable  (out_drv_en),
    .rd_rise (rd_rise),
    .rd_fall (rd_fall),
    .dq_out  (dq_out)
  );

  property p_cs_mask;
    @(posedge ref_clk) disable iff (!resetn)
      chip_select_n |=> !cmd_valid;
  endproperty
  a_cs_mask: assert property (p_cs_mask) else $error("command taken with cs high");

  property p_capture;
    @(posedge ref_clk) disable iff (!resetn)
      (st_q == dcip_pkg::DCIP_ST_ACTIVE && clock_gate && !chip_select_n)
      |=> cmd_valid && cmd_code == $past(raw_cmd) && cmd_addr == $past(addr);
  endproperty
  a_capture: assert property (p_capture) else $error("command not captured");

  property p_code_cs;
    @(posedge ref_clk) disable iff (!resetn)
      cmd_valid |-> !cmd_code[`DCIP_CMD_CS_BIT];
  endproperty
  a_code_cs: assert property (p_code_cs) else $error("cs bit wrong in code");

  property p_gate_low;
    @(posedge ref_clk) disable iff (!resetn)
      (st_q == dcip_pkg::DCIP_ST_ACTIVE && !clock_gate)
      |=> !out_drv_en
          && (!int_clk_en || (power_state == dcip_pkg::DCIP_ST_SREF && clock_gate));
  endproperty
  a_gate_low: assert property (p_gate_low) else $error("drivers not stopped");

  property p_apd;
    @(posedge ref_clk) disable iff (!resetn)
      (st_q == dcip_pkg::DCIP_ST_ACTIVE && !clock_gate && any_row_open)
      |=> power_state == dcip_pkg::DCIP_ST_APD;
  endproperty
  a_apd: assert property (p_apd) else $error("active power-down missed");

  property p_pd_exit;
    @(posedge ref_clk) disable iff (!resetn)
      ((st_q == dcip_pkg::DCIP_ST_PPD || st_q == dcip_pkg::DCIP_ST_APD) && clock_gate)
      |=> power_state == dcip_pkg::DCIP_ST_ACTIVE && out_drv_en;
  endproperty
  a_pd_exit: assert property (p_pd_exit) else $error("power-down exit late");

  property p_pd_bufs;
    @(posedge ref_clk) disable iff (!resetn)
      (st_q == dcip_pkg::DCIP_ST_PPD) |-> !in_buf_en && clk_buf_en;
  endproperty
  a_pd_bufs: assert property (p_pd_bufs) else $error("power-down buffers wrong");

  property p_sref_bufs;
    @(posedge ref_clk) disable iff (!resetn)
      (st_q == dcip_pkg::DCIP_ST_SREF && !clock_gate) |-> !in_buf_en && !clk_buf_en;
  endproperty
  a_sref_bufs: assert property (p_sref_bufs) else $error("self refresh buffers on");

  property p_term;
    @(posedge ref_clk) disable iff (!resetn)
      (st_q != dcip_pkg::DCIP_ST_SREF && termination_control && !ext_term_disable)
      |=> term_en == `DCIP_TERM_ALL;
  endproperty
  a_term: assert property (p_term) else $error("termination not enabled");

  property p_term_off;
    @(posedge ref_clk) disable iff (!resetn)
      ext_term_disable |=> term_en == `DCIP_TERM_NONE;
  endproperty
  a_term_off: assert property (p_term_off) else $error("termination not ignored");
endmodule

// file: dcip_ctrl_partner.sv
// memory controller model that drives the command and control pins
// assumes the bench hands it one request per ref_clk cycle
`timescale 1ns/100ps
module dcip_ctrl_partner (
  input  wire logic        ref_clk,             // timing clock
  input  wire logic        resetn,              // async reset, low active
  input  wire logic [3:0]  req_cmd,             // wanted {cs,ras,cas,we}
  input  wire logic        req_gate,            // wanted clock gate level
  input  wire logic        req_term,            // wanted termination level
  output logic             clock_gate,          // clock-gate pin
  output logic      [3:0]  cmd_pins,            // {cs,ras,cas,we} pins
  output logic             termination_control  // termination pin
);
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      clock_gate          <= 1'b1;
      cmd_pins            <= 4'hf;
      termination_control <= 1'b0;
    end
    else
    begin
      // chip select goes out with the strobes as one code
      cmd_pins            <= req_cmd;
      // a read or write never leaves with the gate low
      clock_gate          <= req_gate | (req_cmd[3:1] == 3'h2);
      termination_control <= req_term;
    end
  end
endmodule

// file: dcip_ctrl_test.sv
// self-checking bench for the control-input front end
// assumes a cycle model of the power states mirrors the pins each edge
`timescale 1ns/100ps
`include "dcip_defines.svh"
module dcip_ctrl_test;
  logic        ref_clk, resetn, req_gate, req_term, any_row_open, ext_term_disable;
  logic        clock_gate, termination_control, cmd_valid;
  logic        int_clk_en, in_buf_en, clk_buf_en, out_drv_en, m_v, m_term;
  logic [3:0]  req_cmd, cmd_pins, cmd_code, power_state, m_code, m_prev;
  logic [3:0]  m_st = dcip_pkg::DCIP_ST_ACTIVE;
  logic [2:0]  bank_addr, cmd_bank, m_bank;
  logic [12:0] addr, cmd_addr, m_addr;
  logic [15:0] rd_rise, rd_fall, dq_out;
  logic [19:0] term_en;
  int          bad_count, compares;

  dcip_ctrl_partner i_dcip_ctrl_partner (.ref_clk(ref_clk), .resetn(resetn),
    .req_cmd(req_cmd), .req_gate(req_gate), .req_term(req_term), .clock_gate(clock_gate),
    .cmd_pins(cmd_pins), .termination_control(termination_control));

  dcip_ctrl i_dcip_ctrl (.ref_clk(ref_clk), .resetn(resetn), .clock_gate(clock_gate),
    .chip_select_n(cmd_pins[3]), .row_strobe_n(cmd_pins[2]), .col_strobe_n(cmd_pins[1]),
    .write_enable_n(cmd_pins[0]), .bank_addr(bank_addr), .addr(addr),
    .termination_control(termination_control), .ext_term_disable(ext_term_disable),
    .any_row_open(any_row_open), .rd_rise(rd_rise), .rd_fall(rd_fall),
    .cmd_code(cmd_code), .cmd_valid(cmd_valid), .cmd_bank(cmd_bank), .cmd_addr(cmd_addr),
    .power_state(power_state), .int_clk_en(int_clk_en), .in_buf_en(in_buf_en),
    .clk_buf_en(clk_buf_en), .out_drv_en(out_drv_en), .term_en(term_en), .dq_out(dq_out));

  function automatic logic [3:0] nxt(input logic [3:0] st, input logic g,
                                     input logic [3:0] p, input logic r);
    if (st != dcip_pkg::DCIP_ST_ACTIVE)
      return g ? dcip_pkg::DCIP_ST_ACTIVE : st;
    if (g)
      return st;
    if (r)
      return dcip_pkg::DCIP_ST_APD;
    return (p == dcip_pkg::DCIP_REF) ? dcip_pkg::DCIP_ST_SREF : dcip_pkg::DCIP_ST_PPD;
  endfunction

  task automatic chk(input string n, input logic [19:0] s, input logic [19:0] e);
    compares++;
    if (s !== e)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic step(input logic [3:0] c, input logic g, input logic r);
    @(posedge ref_clk);
    req_cmd          <= c;
    req_gate         <= g;
    any_row_open     <= r;
    req_term         <= 1'($urandom);
    ext_term_disable <= ($urandom % 4) == 0;
    bank_addr        <= 3'($urandom);
    addr             <= 13'($urandom);
  endtask

  task automatic summarize();
    if (bad_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // pins are read before this edge's updates land, as the device sees them
  always @(posedge ref_clk or negedge resetn)
  begin
    m_prev = m_st;
    m_v = resetn && m_st == dcip_pkg::DCIP_ST_ACTIVE && clock_gate && !cmd_pins[3];
    if (m_v)
    begin
      m_code = cmd_pins;
      m_bank = bank_addr;
      m_addr = addr;
    end
    m_term = termination_control && !ext_term_disable;
    m_st = resetn ? nxt(m_st, clock_gate, cmd_pins, any_row_open) : dcip_pkg::DCIP_ST_ACTIVE;
  end

  always @(negedge ref_clk)
    if (resetn)
    begin
      chk("power_state", power_state, m_st);
      chk("cmd_valid", cmd_valid, m_v);
      if (m_v)
      begin
        chk("cmd_code", cmd_code, m_code);
        chk("cmd_bank", cmd_bank, m_bank);
        chk("cmd_addr", cmd_addr, m_addr);
      end
      else
        chk("cmd_code_idle", cmd_code, `DCIP_CMD_NOP);
      chk("in_buf_en", in_buf_en, m_st == dcip_pkg::DCIP_ST_ACTIVE);
      chk("out_drv_en", out_drv_en, m_st == dcip_pkg::DCIP_ST_ACTIVE);
      chk("clk_buf_en", clk_buf_en, m_st != dcip_pkg::DCIP_ST_SREF || clock_gate);
      chk("int_clk_en", int_clk_en, m_st == dcip_pkg::DCIP_ST_ACTIVE
          || (m_st == dcip_pkg::DCIP_ST_SREF && clock_gate));
      // self refresh drops termination whatever the pin says
      chk("term_en", term_en, (m_term && m_prev != dcip_pkg::DCIP_ST_SREF) ?
          `DCIP_TERM_ALL : `DCIP_TERM_NONE);
    end

  initial
  begin
    ref_clk = 1'b0;
    forever #(`DCIP_CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;
  end

  initial
  begin
    #(2000 * `DCIP_CLK_PERIOD_NS);
    bad_count++;
    summarize();
  end

  initial
  begin
    logic [3:0] c;
    {resetn, req_term, any_row_open, ext_term_disable, bank_addr, addr} = '0;
    {req_cmd, req_gate, rd_rise, rd_fall, bad_count, compares} = '0;
    req_cmd  = 4'hf;
    req_gate = 1'b1;
    void'($urandom(93351));
    repeat (12) @(posedge ref_clk);
    resetn <= 1'b1;
    // every code back to back, then deselects with live strobes
    for (int i = 0; i < 8; i++)
      if (i != 6)
        step(4'(i), 1'b1, 1'b0);
    repeat (4) step({1'b1, 3'($urandom)}, 1'b1, 1'b0);
    // read while asking for the gate low must stay active
    step(dcip_pkg::DCIP_RD, 1'b0, 1'b1);
    repeat (4) step(4'hf, 1'b0, 1'b1);
    repeat (3) step(dcip_pkg::DCIP_ACT, 1'b1, 1'b1);
    repeat (4) step(4'hf, 1'b0, 1'b0);
    repeat (3) step(4'hf, 1'b1, 1'b0);
    step(dcip_pkg::DCIP_REF, 1'b0, 1'b0);
    repeat (5) step({1'b1, 3'($urandom)}, 1'b0, 1'b0);
    repeat (3) step(4'hf, 1'b1, 1'b0);
    repeat (4)
    begin
      @(posedge ref_clk);
      rd_rise <= 16'($urandom);
      rd_fall <= 16'($urandom);
      repeat (3) @(posedge ref_clk);
      #5 chk("dq_rise", dq_out, rd_rise);
      @(negedge ref_clk);
      #5 chk("dq_fall", dq_out, rd_fall);
    end
    repeat (500)
    begin
      c = 4'($urandom);
      step(c == 4'h6 ? 4'h7 : c, ($urandom % 6) != 0, 1'($urandom));
    end
    repeat (4) step(4'hf, 1'b1, 1'b0);
    summarize();
  end
endmodule

// file: dcip_ddr_out.sv
// double-rate read data launcher: one item per edge of the timing clock
// assumes rd_rise and rd_fall are stable from the rising edge onward
`timescale 1ns/100ps
`include "dcip_defines.svh"
module dcip_ddr_out (
  input  wire logic                   ref_clk,  // timing clock
  input  wire logic                   resetn,   // async reset, low active
  input  wire logic                   enable,   // output drivers live
  input  wire logic [`DCIP_DQ_W-1:0]  rd_rise,  // item for high phase
  input  wire logic [`DCIP_DQ_W-1:0]  rd_fall,  // item for low phase
  output logic      [`DCIP_DQ_W-1:0]  dq_out    // double-rate data
);
  logic [`DCIP_DQ_W-1:0] rise_q;
  logic [`DCIP_DQ_W-1:0] fall_q;
  logic [`DCIP_DQ_W-1:0] rise_d;
  logic [`DCIP_DQ_W-1:0] fall_d;

  always_comb
  begin
    rise_d = enable ? rd_rise : rise_q;
    fall_d = enable ? rd_fall : fall_q;
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rise_q <= '0;
      fall_q <= '0;
    end
    else
    begin
      rise_q <= rise_d;
      fall_q <= fall_d;
    end
  end

  // clock-phase mux gives one item on each crossing direction
  assign dq_out = ref_clk ? rise_q : fall_q;
endmodule

// file: dcip_defines.svh
// constants for the control-input front end of the ddr memory device
// assumes a single 20 MHz system clock stands in for the differential timing input
`ifndef DCIP_DEFINES_SVH
`define DCIP_DEFINES_SVH
`define DCIP_CLK_PERIOD_NS   50
`define DCIP_CMD_W           4
`define DCIP_CMD_CS_BIT      3
`define DCIP_CMD_RAS_BIT     2
`define DCIP_CMD_CAS_BIT     1
`define DCIP_CMD_WE_BIT      0
`define DCIP_CMD_NOP         4'h7
`define DCIP_CMD_ACT         4'h3
`define DCIP_CMD_RD          4'h5
`define DCIP_CMD_WR          4'h4
`define DCIP_CMD_PRE         4'h2
`define DCIP_CMD_REF         4'h1
`define DCIP_CMD_MRS         4'h0
`define DCIP_DQ_W            16
`define DCIP_TERM_W          20
`define DCIP_TERM_ALL        20'hfffff
`define DCIP_TERM_NONE       20'h00000
`endif

// file: dcip_pkg.sv
// types shared by the control-input front end
// assumes dcip_defines.svh is on the include path
`include "dcip_defines.svh"
package dcip_pkg;
  typedef enum logic [3:0] {
    DCIP_NOP = `DCIP_CMD_NOP,
    DCIP_ACT = `DCIP_CMD_ACT,
    DCIP_RD  = `DCIP_CMD_RD,
    DCIP_WR  = `DCIP_CMD_WR,
    DCIP_PRE = `DCIP_CMD_PRE,
    DCIP_REF = `DCIP_CMD_REF,
    DCIP_MRS = `DCIP_CMD_MRS
  } dcip_cmd_t;
  typedef enum logic [3:0] {
    DCIP_ST_ACTIVE = 4'h1,
    DCIP_ST_PPD    = 4'h2,
    DCIP_ST_APD    = 4'h4,
    DCIP_ST_SREF   = 4'h8
  } dcip_state_t;
endpackage
